// ==== design/ivm_pkg.sv ====
// constants, vector numbers and helpers of the interrupt vector mapping block
package ivm_pkg;

    localparam int NUM_VEC = 38;
    localparam int VEC_W = 6;
    localparam int WADDR_W = 7;
    localparam int NUM_MISC = 11;
    localparam int PINS_PORTD_MIN = 32;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_EN_LO = 8'h04;
    localparam logic [7:0] OFF_EN_HI = 8'h08;
    localparam logic [7:0] OFF_FLAG_LO = 8'h0C;
    localparam logic [7:0] OFF_FLAG_HI = 8'h10;
    localparam logic [7:0] OFF_REQ_LO = 8'h14;
    localparam logic [7:0] OFF_REQ_HI = 8'h18;
    localparam logic [7:0] OFF_VSEL = 8'h1C;

    // field positions and reset values
    localparam int CTRL_GIE_BIT = 0;
    localparam int CTRL_SPLIT_BIT = 1;
    localparam int VSEL_PRESENT_BIT = 8;
    localparam logic CTRL_GIE_RST = 1'b0;
    localparam logic CTRL_SPLIT_RST = 1'b0;
    localparam logic [NUM_VEC-1:0] EN_RST = 38'h00_0000_0000;
    localparam logic [NUM_VEC-1:0] NMI_MASK = 38'h00_0000_0002;

    // vector numbers
    localparam int VEC_RESET = 0;
    localparam int VEC_NMI = 1;
    localparam int VEC_VLM = 2;
    localparam int VEC_RTC_OVF_CMP = 3;
    localparam int VEC_RTC_PERIODIC = 4;
    localparam int VEC_TA_OVF = 7;
    localparam int VEC_TA_HUNF = 8;
    localparam int VEC_TA_CMP0 = 9;
    localparam int VEC_TB0 = 12;
    localparam int VEC_TB1 = 13;
    localparam int VEC_TD_OVF = 14;
    localparam int VEC_TD_TRIG = 15;
    localparam int VEC_TW_CLIENT = 16;
    localparam int VEC_TW_HOST = 17;
    localparam int VEC_SER0_RXC = 19;
    localparam int VEC_PORTD = 22;
    localparam int VEC_CONV_RES = 24;
    localparam int VEC_CONV_WIN = 25;
    localparam int VEC_TB2 = 30;
    localparam int VEC_SER1_RXC = 31;
    localparam int VEC_EE = 35;
    localparam int VEC_SER2_RXC = 37;

    // vectors of the plain one-source peripherals, index 10 first
    localparam logic [NUM_MISC-1:0][VEC_W-1:0] MISC_VEC = {6'h24, 6'h22, 6'h1D, 6'h1C,
        6'h1B, 6'h1A, 6'h17, 6'h16, 6'h12, 6'h06, 6'h05};

    // word program address of a vector
    function automatic logic [WADDR_W-1:0] vec_word_addr(input logic [VEC_W-1:0] v);
        return {v, 1'b0};
    endfunction

    // vectors that exist as interrupts in a package variant
    function automatic logic [NUM_VEC-1:0] present_mask(input int pins);
        logic [NUM_VEC-1:0] m;
        m = '1;
        m[VEC_RESET] = 1'b0;
        if (pins < PINS_PORTD_MIN)
        begin
            m[VEC_PORTD] = 1'b0;
        end
        return m;
    endfunction

endpackage

// ==== design/ivm_if.sv ====
// carriers between the mapping top and its flag bank and address lookup
`timescale 1ns/10ps
interface ivm_flag_if;
    logic [37:0] ev;
    logic [37:0] clr;
    logic [37:0] en;
    logic [37:0] present;
    logic gie;
    logic [37:0] flags;
    logic [37:0] req;
    modport bank (input ev, clr, en, present, gie, output flags, req);
    modport ctrl (output ev, clr, en, present, gie, input flags, req);
endinterface

interface ivm_vec_if;
    logic [5:0] sel;
    logic load;
    logic [6:0] addr;
    logic present;
    modport lookup (input sel, load, output addr, present);
    modport ctrl (output sel, load, input addr, present);
endinterface

// ==== design/ivm_flag_bank.sv ====
// sticky interrupt flags and level requests for all vectors
`timescale 1ns/10ps
module ivm_flag_bank (
    input wire logic pclk,
    input wire logic presetn,
    ivm_flag_if.bank f
);
    typedef struct packed {
        logic [ivm_pkg::NUM_VEC-1:0] flags;
        logic [ivm_pkg::NUM_VEC-1:0] req;
    } ivm_bank_state_t;

    ivm_bank_state_t s_q;
    ivm_bank_state_t s_d;
    logic [ivm_pkg::NUM_VEC-1:0] gate;

    always_comb
    begin
        s_d = s_q;
        // set regardless of enable, set beats clear
        s_d.flags = (s_q.flags & ~f.clr) | (f.ev & f.present);
        s_d.flags[ivm_pkg::VEC_RESET] = 1'b0;
        gate = f.gie ? '1 : ivm_pkg::NMI_MASK;
        // request is enable and flag, gated by global enable except nmi, absent never
        s_d.req = s_q.flags & f.en & gate & f.present;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign f.flags = s_q.flags;
    assign f.req = s_q.req;

    a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (|(f.ev & f.present)) |=> ((s_q.flags & $past(f.ev & f.present))
        == $past(f.ev & f.present)))
        else $error("event did not set its flag");

endmodule

// ==== design/ivm_vec_lookup.sv ====
// word program address lookup for a selected vector
`timescale 1ns/10ps
module ivm_vec_lookup #(
    parameter int PIN_COUNT = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    ivm_vec_if.lookup v
);
    typedef struct packed {
        logic [ivm_pkg::WADDR_W-1:0] addr;
        logic present;
    } ivm_look_state_t;

    localparam logic [ivm_pkg::NUM_VEC-1:0] PMASK = ivm_pkg::present_mask(PIN_COUNT);

    ivm_look_state_t s_q;
    ivm_look_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (v.load)
        begin
            // address is twice the vector number
            s_d.addr = ivm_pkg::vec_word_addr(v.sel);
            s_d.present = (v.sel == 6'h00) ||
                ((v.sel < 6'h26) && PMASK[v.sel]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign v.addr = s_q.addr;
    assign v.present = s_q.present;

    a_vec_word_addr: assert property (@(posedge pclk) disable iff (!presetn)
        v.load |=> (v.addr == {$past(v.sel), 1'b0}))
        else $error("vector address is not twice the vector number");

endmodule

// ==== design/ivm_top.sv ====
// interrupt vector mapping: source routing, enables, flags, apb registers
// Behaviour
// - flags set on condition even when disabled
// - software enable bit per source only
// - request when enable and flag both set
// - no request without global enable, except nmi on vector 1
// - request stays until flag cleared
// - each vector has at most one source at a time, 0 none, 7-11 chosen by mode
// - vector 1 nmi from memory scan, needs its enable bit but not global enable
// - vector 2 carries supply level monitor
// - rtc vectors 3 overflow/compare, 4 periodic
// - vector 7 overflow or low underflow
// - vector 8 unused normal, high underflow split
// - vectors 9-11 compares or low compares
// - timer b vectors 0x18, 0x1A, 0x3C
// - timer d overflow 14, trigger 15
// - two-wire client 0x20, host 0x22
// - serial receive, empty, transmit complete vectors
// - converter result 24, window 25
// - eeprom ready on vector 35
`timescale 1ns/10ps
module ivm_top #(
    parameter int PIN_COUNT = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic memory_scan_checker,
    input wire logic supply_level_monitor_irq,
    input wire logic rtc_overflow_compare_irq,
    input wire logic rtc_periodic_irq,
    input wire logic timer_a_overflow_irq,
    input wire logic timer_a_low_underflow_irq,
    input wire logic timer_a_high_underflow_irq,
    input wire logic [2:0] timer_a_compare_irq,
    input wire logic [2:0] timer_a_low_compare_irq,
    input wire logic [2:0] timer_b_capture_irq,
    input wire logic timer_d_overflow_irq,
    input wire logic timer_d_trigger_irq,
    input wire logic two_wire_client_irq,
    input wire logic two_wire_host_irq,
    input wire logic [2:0] serial_rx_complete_irq,
    input wire logic [1:0] serial_tx_empty_irq,
    input wire logic [1:0] serial_tx_complete_irq,
    input wire logic converter_result_irq,
    input wire logic converter_window_irq,
    input wire logic eeprom_ready_irq,
    input wire logic [10:0] misc_irq,
    output logic [37:0] irq_req
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic gie;
        logic split;
        logic [ivm_pkg::NUM_VEC-1:0] en;
        logic [ivm_pkg::VEC_W-1:0] sel;
        logic sel_load;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } ivm_top_state_t;

    ivm_top_state_t s_q;
    ivm_top_state_t s_d;

    ivm_flag_if fif ();
    ivm_vec_if vif ();

    logic [ivm_pkg::NUM_VEC-1:0] ev;
    logic [ivm_pkg::NUM_VEC-1:0] clr;
    logic access;
    logic hit;
    logic [7:0] reg_off;
    logic [31:0] rd_val;

    // -----------------------------------------------------------------
    // source routing
    // -----------------------------------------------------------------
    always_comb
    begin
        ev = '0;
        ev[ivm_pkg::VEC_NMI] = memory_scan_checker;
        ev[ivm_pkg::VEC_VLM] = supply_level_monitor_irq;
        ev[ivm_pkg::VEC_RTC_OVF_CMP] = rtc_overflow_compare_irq;
        ev[ivm_pkg::VEC_RTC_PERIODIC] = rtc_periodic_irq;
        // overflow or low underflow by mode
        ev[ivm_pkg::VEC_TA_OVF] = s_q.split ? timer_a_low_underflow_irq
            : timer_a_overflow_irq;
        // high underflow only in split mode
        ev[ivm_pkg::VEC_TA_HUNF] = s_q.split & timer_a_high_underflow_irq;
        ev[ivm_pkg::VEC_TA_CMP0 +: 3] = s_q.split ? timer_a_low_compare_irq
            : timer_a_compare_irq;
        ev[ivm_pkg::VEC_TB0] = timer_b_capture_irq[0];
        ev[ivm_pkg::VEC_TB1] = timer_b_capture_irq[1];
        ev[ivm_pkg::VEC_TB2] = timer_b_capture_irq[2];
        ev[ivm_pkg::VEC_TD_OVF] = timer_d_overflow_irq;
        ev[ivm_pkg::VEC_TD_TRIG] = timer_d_trigger_irq;
        ev[ivm_pkg::VEC_TW_CLIENT] = two_wire_client_irq;
        ev[ivm_pkg::VEC_TW_HOST] = two_wire_host_irq;
        ev[ivm_pkg::VEC_SER0_RXC] = serial_rx_complete_irq[0];
        ev[ivm_pkg::VEC_SER0_RXC + 1] = serial_tx_empty_irq[0];
        ev[ivm_pkg::VEC_SER0_RXC + 2] = serial_tx_complete_irq[0];
        ev[ivm_pkg::VEC_SER1_RXC] = serial_rx_complete_irq[1];
        ev[ivm_pkg::VEC_SER1_RXC + 1] = serial_tx_empty_irq[1];
        ev[ivm_pkg::VEC_SER1_RXC + 2] = serial_tx_complete_irq[1];
        ev[ivm_pkg::VEC_SER2_RXC] = serial_rx_complete_irq[2];
        ev[ivm_pkg::VEC_CONV_RES] = converter_result_irq;
        ev[ivm_pkg::VEC_CONV_WIN] = converter_window_irq;
        ev[ivm_pkg::VEC_EE] = eeprom_ready_irq;
        for (int i = 0; i < ivm_pkg::NUM_MISC; i++)
        begin
            ev[ivm_pkg::MISC_VEC[i]] = misc_irq[i];
        end
    end

    // -----------------------------------------------------------------
    // apb register access
    // -----------------------------------------------------------------
    assign access = psel & penable;
    assign reg_off = paddr[7:0];
    assign hit = (paddr[31:8] == 24'h00_0000) && (reg_off[1:0] == 2'h0) &&
        (reg_off <= ivm_pkg::OFF_VSEL);

    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (reg_off)
            ivm_pkg::OFF_CTRL:
            begin
                rd_val[ivm_pkg::CTRL_GIE_BIT] = s_q.gie;
                rd_val[ivm_pkg::CTRL_SPLIT_BIT] = s_q.split;
            end
            ivm_pkg::OFF_EN_LO: rd_val = s_q.en[31:0];
            ivm_pkg::OFF_EN_HI: rd_val[5:0] = s_q.en[37:32];
            ivm_pkg::OFF_FLAG_LO: rd_val = fif.flags[31:0];
            ivm_pkg::OFF_FLAG_HI: rd_val[5:0] = fif.flags[37:32];
            ivm_pkg::OFF_REQ_LO: rd_val = fif.req[31:0];
            ivm_pkg::OFF_REQ_HI: rd_val[5:0] = fif.req[37:32];
            ivm_pkg::OFF_VSEL:
            begin
                rd_val[ivm_pkg::WADDR_W-1:0] = vif.addr;
                rd_val[ivm_pkg::VSEL_PRESENT_BIT] = vif.present;
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        s_d = s_q;
        s_d.sel_load = 1'b0;
        clr = '0;
        if (access && !s_q.ready)
        begin
            // one wait state, answer prepared from flops
            s_d.ready = 1'b1;
            s_d.slverr = !hit;
            s_d.rdata = (hit && !pwrite) ? rd_val : 32'h0000_0000;
        end
        else
        begin
            s_d.ready = 1'b0;
            s_d.slverr = 1'b0;
            s_d.rdata = 32'h0000_0000;
        end
        if (access && s_q.ready && pwrite && hit)
        begin
            case (reg_off)
                ivm_pkg::OFF_CTRL:
                begin
                    s_d.gie = pwdata[ivm_pkg::CTRL_GIE_BIT];
                    s_d.split = pwdata[ivm_pkg::CTRL_SPLIT_BIT];
                end
                ivm_pkg::OFF_EN_LO: s_d.en[31:0] = pwdata;
                ivm_pkg::OFF_EN_HI: s_d.en[37:32] = pwdata[5:0];
                ivm_pkg::OFF_FLAG_LO: clr[31:0] = pwdata;
                ivm_pkg::OFF_FLAG_HI: clr[37:32] = pwdata[5:0];
                ivm_pkg::OFF_VSEL:
                begin
                    s_d.sel = pwdata[ivm_pkg::VEC_W-1:0];
                    s_d.sel_load = 1'b1;
                end
                default: s_d.sel_load = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q.gie <= ivm_pkg::CTRL_GIE_RST;
            s_q.split <= ivm_pkg::CTRL_SPLIT_RST;
            s_q.en <= ivm_pkg::EN_RST;
            s_q.sel <= '0;
            s_q.sel_load <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
            s_q.ready <= 1'b0;
            s_q.slverr <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // -----------------------------------------------------------------
    // submodules
    // -----------------------------------------------------------------
    assign fif.ev = ev;
    assign fif.clr = clr;
    assign fif.en = s_q.en;
    assign fif.gie = s_q.gie;
    assign fif.present = ivm_pkg::present_mask(PIN_COUNT);
    assign vif.sel = s_q.sel;
    assign vif.load = s_q.sel_load;

    ivm_flag_bank u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .f(fif)
    );

    ivm_vec_lookup #(
        .PIN_COUNT(PIN_COUNT)
    ) u_lookup (
        .pclk(pclk),
        .presetn(presetn),
        .v(vif)
    );

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.slverr;
    assign irq_req = fif.req;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_first_access;
        psel && penable && !pready;
    endsequence

    a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup ##1 s_first_access |=> pready)
        else $error("apb answer not after one wait state");

    a_req_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_req & ~$past(s_q.en)) == 38'h00_0000_0000)
        else $error("request without its enable");

    a_req_needs_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_req & ~$past(fif.flags)) == 38'h00_0000_0000)
        else $error("request without its flag");

    a_no_gie_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.gie) [*2] |-> ((irq_req & ~ivm_pkg::NMI_MASK) == 38'h00_0000_0000))
        else $error("maskable request without global enable");

    a_nmi_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
        (fif.flags[ivm_pkg::VEC_NMI] && s_q.en[ivm_pkg::VEC_NMI]) |=>
        irq_req[ivm_pkg::VEC_NMI])
        else $error("nmi request missing");

    a_req_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_req[ivm_pkg::VEC_EE] && fif.flags[ivm_pkg::VEC_EE] &&
        s_q.en[ivm_pkg::VEC_EE] && s_q.gie) |=> irq_req[ivm_pkg::VEC_EE])
        else $error("request dropped while flag set");

    a_reset_vec_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !irq_req[ivm_pkg::VEC_RESET] && !fif.flags[ivm_pkg::VEC_RESET])
        else $error("reset entry raised as interrupt");

    a_absent_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (fif.flags & ~ivm_pkg::present_mask(PIN_COUNT)) == 38'h00_0000_0000)
        else $error("absent vector raised");

    a_hunf_normal: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.split && timer_a_high_underflow_irq && !fif.flags[ivm_pkg::VEC_TA_HUNF]) |=>
        !fif.flags[ivm_pkg::VEC_TA_HUNF])
        else $error("vector 8 used in normal mode");

    a_split_lunf: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.split && timer_a_low_underflow_irq) |=> fif.flags[ivm_pkg::VEC_TA_OVF])
        else $error("low underflow not on vector 7");

    sequence s_ee_event;
        eeprom_ready_irq;
    endsequence

    sequence s_ee_armed;
        s_q.en[ivm_pkg::VEC_EE] && s_q.gie;
    endsequence

    a_ee_req_latency: assert property (@(posedge pclk) disable iff (!presetn)
        s_ee_event ##1 s_ee_armed |=> irq_req[ivm_pkg::VEC_EE])
        else $error("eeprom request not two edges after event");

    a_req_exact: assert property (@(posedge pclk) disable iff (!presetn)
        irq_req == $past(fif.flags & s_q.en & (s_q.gie ? {38{1'h1}} : ivm_pkg::NMI_MASK)))
        else $error("request is not enable and flag");

    a_normal_ovf: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.split && timer_a_overflow_irq) |=> fif.flags[ivm_pkg::VEC_TA_OVF])
        else $error("overflow not on vector 7");

    a_split_hunf: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.split && timer_a_high_underflow_irq) |=> fif.flags[ivm_pkg::VEC_TA_HUNF])
        else $error("high underflow not on vector 8");

    a_normal_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        (!s_q.split && timer_a_compare_irq[0]) |=> fif.flags[ivm_pkg::VEC_TA_CMP0])
        else $error("compare 0 not on vector 9");

    a_split_lcmp: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.split && timer_a_low_compare_irq[2]) |=> fif.flags[ivm_pkg::VEC_TA_CMP0 + 2])
        else $error("low compare 2 not on vector 11");

    a_nmi_source: assert property (@(posedge pclk) disable iff (!presetn)
        memory_scan_checker |=> fif.flags[ivm_pkg::VEC_NMI])
        else $error("memory scan event not on vector 1");

    a_tb2_source: assert property (@(posedge pclk) disable iff (!presetn)
        timer_b_capture_irq[2] |=> fif.flags[ivm_pkg::VEC_TB2])
        else $error("third timer b not on vector 30");

endmodule

// ==== verification/ivm_cpu_model.sv ====
// processor-side model that fetches the vector of the lowest pending request
`timescale 1ns/10ps
module ivm_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [37:0] irq_req,
    output logic fetching,
    output logic [6:0] fetch_addr
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fetching <= 1'h0;
            fetch_addr <= 7'h00;
        end
        else
        begin
            fetching <= |irq_req;
            fetch_addr <= 7'h00;
            // lowest vector wins; word address is twice the number
            for (int v = 37; v >= 0; v--)
            begin
                if (irq_req[v])
                begin
                    fetch_addr <= 7'(2 * v);
                end
            end
        end
    end
endmodule

// ==== verification/interrupt_vector_mapping_tb.sv ====
// self-checking bench for the interrupt vector mapping block
`timescale 1ns/10ps
module interrupt_vector_mapping_tb;
    typedef struct {logic rd; logic [31:0] d; logic e;} ivm_note_t;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [37:0] src = 38'h00_0000_0000;
    logic alt = 1'h0;
    logic [37:0] irq_req;
    logic [6:0] fetch_addr;
    logic fetching;
    ivm_note_t notes[$];
    ivm_note_t cur;
    int mismatches = 0;
    int total_checks = 0;

    // ----------------------------------------
    // clock, design and processor model
    // ----------------------------------------
    always #25 pclk = ~pclk;

    ivm_top #(.PIN_COUNT(28)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .memory_scan_checker(src[1]), .supply_level_monitor_irq(src[2]),
        .rtc_overflow_compare_irq(src[3]), .rtc_periodic_irq(src[4]),
        .timer_a_overflow_irq(src[7] & ~alt), .timer_a_low_underflow_irq(src[7] & alt),
        .timer_a_high_underflow_irq(src[8]),
        .timer_a_compare_irq(src[11:9] & {3{~alt}}),
        .timer_a_low_compare_irq(src[11:9] & {3{alt}}),
        .timer_b_capture_irq({src[30], src[13], src[12]}),
        .timer_d_overflow_irq(src[14]), .timer_d_trigger_irq(src[15]),
        .two_wire_client_irq(src[16]), .two_wire_host_irq(src[17]),
        .serial_rx_complete_irq({src[37], src[31], src[19]}),
        .serial_tx_empty_irq({src[32], src[20]}),
        .serial_tx_complete_irq({src[33], src[21]}),
        .converter_result_irq(src[24]), .converter_window_irq(src[25]),
        .eeprom_ready_irq(src[35]),
        .misc_irq({src[36], src[34], src[29:26], src[23:22], src[18], src[6:5]}),
        .irq_req(irq_req)
    );

    ivm_cpu_model cpu_u (
        .pclk(pclk), .presetn(presetn), .irq_req(irq_req),
        .fetching(fetching), .fetch_addr(fetch_addr)
    );

    // ----------------------------------------
    // comparison, bus tasks and closing
    // ----------------------------------------
    task automatic check(input logic [37:0] seen, input logic [37:0] exp, input string msg);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        notes.push_back('{rd: !w, d: ed, e: ee});
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, {24'h00_0000, a}, d, 32'h0000_0000, 1'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed);
        apb(1'h0, {24'h00_0000, a}, 32'h0000_0000, ed, 1'h0);
    endtask

    task automatic rd38(input logic [7:0] lo, input logic [37:0] exp);
        rd(lo, exp[31:0]);
        rd(lo + 8'h04, {26'h000_0000, exp[37:32]});
    endtask

    task automatic pulse(input logic [37:0] m);
        @(posedge pclk);
        src <= m;
        @(posedge pclk);
        src <= 38'h00_0000_0000;
    endtask

    task automatic clr_all();
        wr(ivm_pkg::OFF_FLAG_LO, 32'hFFFF_FFFF);
        wr(ivm_pkg::OFF_FLAG_HI, 32'h0000_003F);
    endtask

    // result watcher takes the oldest note at each bus answer
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'h1 && notes.size() > 0)
        begin
            cur = notes.pop_front();
            if (cur.rd)
                check({6'h00, prdata}, {6'h00, cur.d}, "read data");
            check({37'h0, pslverr}, {37'h0, cur.e}, "error response");
        end
    end

    initial
    begin
        #(50 * 10000);
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        logic [37:0] en;
        logic [37:0] f;
        logic g;
        void'($urandom(32'h6802D02B));
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        for (int a = 0; a <= 24; a += 4)
            rd(a[7:0], 32'h0000_0000);
        $display("test reset values done");

        for (int v = 1; v < 38; v++)
        begin
            if (v == 8 || v == 22)
                continue;
            pulse(38'h1 << v);
            rd38(ivm_pkg::OFF_FLAG_LO, 38'h1 << v);
            clr_all();
        end
        pulse(38'h1 << 8);
        rd38(ivm_pkg::OFF_FLAG_LO, 38'h0);
        wr(ivm_pkg::OFF_CTRL, 32'h0000_0002);
        alt <= 1'h1;
        for (int v = 7; v < 12; v++)
        begin
            pulse(38'h1 << v);
            rd38(ivm_pkg::OFF_FLAG_LO, 38'h1 << v);
            clr_all();
        end
        wr(ivm_pkg::OFF_CTRL, 32'h0000_0000);
        alt <= 1'h0;
        $display("test source mapping done");

        for (int i = 0; i < 12; i++)
        begin
            en[31:0] = $urandom();
            en[37:32] = 6'($urandom());
            f[31:0] = $urandom();
            f[37:32] = 6'($urandom());
            f = f & 38'h3F_FFBF_FEFE;
            g = 1'($urandom());
            wr(ivm_pkg::OFF_EN_LO, en[31:0]);
            wr(ivm_pkg::OFF_EN_HI, {26'h000_0000, en[37:32]});
            wr(ivm_pkg::OFF_CTRL, {31'h0000_0000, g});
            pulse(f);
            rd38(ivm_pkg::OFF_FLAG_LO, f);
            rd38(ivm_pkg::OFF_REQ_LO, f & en & (g ? {38{1'h1}} : ivm_pkg::NMI_MASK));
            clr_all();
            rd38(ivm_pkg::OFF_REQ_LO, 38'h0);
        end
        $display("test random gating done");

        wr(ivm_pkg::OFF_EN_LO, 32'h0000_0002);
        wr(ivm_pkg::OFF_EN_HI, 32'h0000_0008);
        wr(ivm_pkg::OFF_CTRL, 32'h0000_0001);
        pulse(38'h1 << 35);
        #1;
        check(irq_req, 38'h0, "request before latency");
        @(posedge pclk);
        #1;
        check(irq_req, 38'h1 << 35, "request after event");
        repeat (20) @(posedge pclk);
        #1;
        check(irq_req, 38'h1 << 35, "request held");
        check({30'h0, fetching, fetch_addr}, {30'h0, 1'h1, 7'h46}, "eeprom fetch");
        wr(ivm_pkg::OFF_FLAG_HI, 32'h0000_0008);
        #1;
        check(irq_req, 38'h1 << 35, "request one edge after clear");
        @(posedge pclk);
        #1;
        check(irq_req, 38'h0, "request dropped");
        wr(ivm_pkg::OFF_CTRL, 32'h0000_0000);
        pulse(38'h2);
        rd38(ivm_pkg::OFF_REQ_LO, 38'h2);
        check({31'h0, fetch_addr}, {31'h0, 7'h02}, "nmi fetch");
        clr_all();
        $display("test level request done");

        for (int v = 0; v < 38; v++)
        begin
            if (v == 22)
                continue;
            wr(ivm_pkg::OFF_VSEL, 32'(v));
            rd(ivm_pkg::OFF_VSEL, 32'h0000_0100 | 32'(2 * v));
        end
        $display("test word addresses done");

        wr(ivm_pkg::OFF_EN_LO, 32'hFFFF_FFFF);
        wr(ivm_pkg::OFF_CTRL, 32'h0000_0001);
        pulse(38'h1 << 22);
        rd38(ivm_pkg::OFF_REQ_LO, 38'h0);
        clr_all();
        apb(1'h0, 32'h0000_0020, 32'h0000_0000, 32'h0000_0000, 1'h1);
        apb(1'h1, 32'h0000_0006, 32'h0000_0000, 32'h0000_0000, 1'h1);
        apb(1'h1, 32'h0000_0100, 32'h0000_0000, 32'h0000_0000, 1'h1);
        wr(ivm_pkg::OFF_REQ_LO, 32'hFFFF_FFFF);
        rd(ivm_pkg::OFF_REQ_LO, 32'h0000_0000);
        rd(ivm_pkg::OFF_CTRL, 32'h0000_0001);
        $display("test absent and refused done");
        stop_test();
    end
endmodule
